// file: design/hblank_sync.sv
/*
 * Horizontal character counter, display enable, blanking and sync with
 * skew, plus the controller index/data register port with group zero
 * write protection.
 * Assumes char_en is a one-cycle pulse per character clock from an
 * outside divider, and that port strobes are synchronous one-cycle pulses.
 * The eight-bit counter caps a line at 256 characters; longer totals
 * are clamped rather than wrapped.
 */
`timescale 1ns/1ps
module hblank_sync
    import hblank_sync_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic char_en,
    input wire logic text_mode,
    input wire logic index_wr,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [7:0] wr_data,
    output logic [7:0] index_q,
    output logic [7:0] rd_data,
    output logic h_blank,
    output logic h_sync,
    output logic disp_en,
    output logic line_start
);
    // Register file, counter and undelayed timing levels
    typedef struct packed {
        logic [6:0] index;
        logic [7:0] rd;
        logic [7:0] total;
        logic [7:0] disp_end;
        logic [7:0] blank_start;
        logic [7:0] blank_end_skew;
        logic [7:0] sync_start;
        logic [7:0] sync_end;
        logic [7:0] protect;
        logic [7:0] count;
        logic blank;
        logic sync;
        logic active;
        logic sol;
    } hs_state_t;

    // Whole register file and timing state, registered in one place
    hs_state_t state_ff;
    hs_state_t nxt_state;
    // Decoded compare values, delay selects and delay-line outputs
    logic [5:0] blank_end_val;
    logic [4:0] sync_end_val;
    logic [7:0] line_last;
    logic [8:0] line_sum;
    logic [2:0] sync_delay;
    logic [2:0] disp_delay;
    logic wr_blocked;
    logic sync_dly;
    logic disp_dly;
    logic [7:0] reg_rd;

    // Six-bit blank end combines two registers
    assign blank_end_val = {state_ff.sync_end[blank_end_msb_bit],
                            state_ff.blank_end_skew[4:0]};
    assign sync_end_val = state_ff.sync_end[4:0];
    // A total near the top of its range would wrap the eight-bit sum to a
    // small value and restart the line within four characters; clamp it instead
    assign line_sum = {1'b0, state_ff.total}
                      + 9'(total_extra - 8'h01);
    assign line_last = line_sum[8] ? 8'hFF : line_sum[7:0];
    // Protection is judged on the index that stands in this cycle
    assign wr_blocked = state_ff.protect[protect_bit]
                        && (state_ff.index <= group0_last_idx);
    // Text modes add one more character of sync delay
    assign sync_delay = {1'b0, state_ff.sync_end[skew_lsb+1:skew_lsb]}
                        + (text_mode ? {1'b0, text_sync_extra} : 3'h0);
    // Display skew is its own two-bit field with no mode term
    assign disp_delay = {1'b0,
                         state_ff.blank_end_skew[skew_lsb+1:skew_lsb]};

    // Read mux; bit 7 of blank end always reads back as one
    always_comb begin
        unique case (state_ff.index)
            line_total_idx: reg_rd = state_ff.total;
            disp_end_idx: reg_rd = state_ff.disp_end;
            blank_start_idx: reg_rd = state_ff.blank_start;
            blank_end_skew_idx: reg_rd = {1'b1,
                state_ff.blank_end_skew[6:0]};
            sync_start_idx: reg_rd = state_ff.sync_start;
            sync_end_idx: reg_rd = state_ff.sync_end;
            protect_idx: reg_rd = state_ff.protect;
            default: reg_rd = 8'h00;
        endcase
    end

    // Register port, counter and raw timing levels
    always_comb begin
        nxt_state = state_ff;
        nxt_state.sol = 1'b0;
        // Only seven index bits are stored; the top port bit reads as zero
        if (index_wr) begin
            nxt_state.index = wr_data[6:0];
        end
        // Read data stands until the next read strobe
        if (data_rd) begin
            nxt_state.rd = reg_rd;
        end
        // Protected group writes are silently dropped
        if (data_wr && !wr_blocked) begin
            unique case (state_ff.index)
                line_total_idx: nxt_state.total = wr_data;
                disp_end_idx: nxt_state.disp_end = wr_data;
                blank_start_idx: nxt_state.blank_start = wr_data;
                blank_end_skew_idx: nxt_state.blank_end_skew =
                    {1'b1, wr_data[6:0]};
                sync_start_idx: nxt_state.sync_start = wr_data;
                sync_end_idx: nxt_state.sync_end = wr_data;
                protect_idx: nxt_state.protect = wr_data;
                default: ;
            endcase
        end
        // Everything below moves only on a character tick
        if (char_en) begin
            // Count wraps at the total register plus four, clamped to 255, to begin a new line
            if (state_ff.count >= line_last) begin
                nxt_state.count = 8'h00;
                nxt_state.sol = 1'b1;
                nxt_state.active = 1'b1;
            end else begin
                nxt_state.count = state_ff.count + 8'h01;
            end
            // Window closes after the last active character
            if (state_ff.count == state_ff.disp_end) begin
                nxt_state.active = 1'b0;
            end
            // Start compares win over end compares in the same character
            if (state_ff.count[5:0] == blank_end_val) begin
                nxt_state.blank = 1'b0;
            end
            if (state_ff.count == state_ff.blank_start) begin
                nxt_state.blank = 1'b1;
            end
            // Sync end looks at five count bits only, so sync stays short
            if (state_ff.count[4:0] == sync_end_val) begin
                nxt_state.sync = 1'b0;
            end
            if (state_ff.count == state_ff.sync_start) begin
                nxt_state.sync = 1'b1;
            end
        end
    end

    // Reset values stand in for registers that power up undefined
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff.index <= index_rst[6:0];
            state_ff.rd <= 8'h00;
            state_ff.total <= line_total_rst;
            state_ff.disp_end <= disp_end_rst;
            state_ff.blank_start <= blank_start_rst;
            state_ff.blank_end_skew <= blank_end_skew_rst;
            state_ff.sync_start <= sync_start_rst;
            state_ff.sync_end <= sync_end_rst;
            state_ff.protect <= protect_rst;
            state_ff.count <= 8'h00;
            state_ff.blank <= 1'b0;
            state_ff.sync <= 1'b0;
            state_ff.active <= 1'b1;
            state_ff.sol <= 1'b0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // Sync delayed by skew and mode; both edges move together
    skew_delay #(
        .max_delay(skew_depth)
    ) u_sync_dly (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .adv(char_en),
        .din(state_ff.sync),
        .sel(sync_delay),
        .dout(sync_dly)
    );

    // Display window delayed by its own skew field
    skew_delay #(
        .max_delay(skew_depth)
    ) u_disp_dly (
        .sys_clk(sys_clk),
        .reset_n(reset_n),
        .adv(char_en),
        .din(state_ff.active),
        .sel(disp_delay),
        .dout(disp_dly)
    );

    // Outputs come straight from registers
    assign index_q = {1'b0, state_ff.index};
    assign rd_data = state_ff.rd;
    assign h_blank = state_ff.blank;
    assign h_sync = sync_dly;
    assign disp_en = disp_dly;
    assign line_start = state_ff.sol;
endmodule : hblank_sync

// file: design/hblank_sync_pkg.sv
/*
 * Constants for the horizontal blank/sync timing block: register indices,
 * field positions, reset values and fixed widths.
 * Assumes the block is reached through an index/data port pair.
 */
package hblank_sync_pkg;
    // Register indices behind the data port
    localparam logic [6:0] line_total_idx = 7'h00;
    localparam logic [6:0] disp_end_idx = 7'h01;
    localparam logic [6:0] blank_start_idx = 7'h02;
    localparam logic [6:0] blank_end_skew_idx = 7'h03;
    localparam logic [6:0] sync_start_idx = 7'h04;
    localparam logic [6:0] sync_end_idx = 7'h05;
    localparam logic [6:0] protect_idx = 7'h11;
    // Last index of protection group zero
    localparam logic [6:0] group0_last_idx = 7'h07;
    // Field positions
    localparam int skew_lsb = 5;
    localparam int protect_bit = 7;
    localparam int blank_end_msb_bit = 7;
    // Reset values
    localparam logic [7:0] line_total_rst = 8'h00;
    localparam logic [7:0] disp_end_rst = 8'h4F;
    localparam logic [7:0] blank_start_rst = 8'h50;
    localparam logic [7:0] blank_end_skew_rst = 8'h82;
    localparam logic [7:0] sync_start_rst = 8'h55;
    localparam logic [7:0] sync_end_rst = 8'h00;
    localparam logic [7:0] protect_rst = 8'h00;
    localparam logic [7:0] index_rst = 8'h00;
    // Line length is the total register plus this amount
    localparam logic [7:0] total_extra = 8'h05;
    // Extra sync delay applied in text modes, character clocks
    localparam logic [1:0] text_sync_extra = 2'h1;
    // Depth of the skew delay lines
    localparam int skew_depth = 6;
endpackage : hblank_sync_pkg

// file: design/skew_delay.sv
/*
 * Variable delay of a one-bit level by zero to max_delay enable ticks.
 * Assumes one clock and a one-cycle advance enable from the caller.
 */
`timescale 1ns/1ps
module skew_delay #(
    parameter int max_delay = 6
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic adv,
    input wire logic din,
    input wire logic [2:0] sel,
    output logic dout
);
    typedef struct packed {
        logic [max_delay-1:0] taps;
        logic q;
    } dly_state_t;

    dly_state_t state_ff;
    dly_state_t nxt_state;

    // Shift on each character tick, pick the tap given by sel
    always_comb begin
        nxt_state = state_ff;
        if (adv) begin
            nxt_state.taps = {state_ff.taps[max_delay-2:0], din};
            if (sel == 3'h0) begin
                nxt_state.q = din;
            end else begin
                nxt_state.q = state_ff.taps[sel-3'h1];
            end
        end
    end

    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_ff <= '0;
        end else begin
            state_ff <= nxt_state;
        end
    end

    assign dout = state_ff.q;
endmodule : skew_delay

// file: test/display_sink.sv
/* Display path model: notes the line position of each edge it sees.
   Assumes one character per clock and line_start at each line. */
`timescale 1ns/1ps
module display_sink (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic h_blank,
    input wire logic h_sync,
    input wire logic disp_en,
    input wire logic line_start,
    output logic [7:0] blank_on,
    output logic [7:0] blank_off,
    output logic [7:0] sync_on,
    output logic [7:0] disp_on,
    output logic [7:0] sync_off,
    output logic [7:0] disp_off
);
    logic [7:0] pos_ff;
    logic [2:0] last_ff;
    // Position restarts at each line pulse; edges are stamped with it
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            pos_ff <= 8'h00;
            last_ff <= 3'h0;
            {blank_on, blank_off, sync_on, disp_on} <= 32'h0;
            {sync_off, disp_off} <= 16'h0;
        end else begin
            pos_ff <= line_start ? 8'h01 : pos_ff + 8'h01;
            last_ff <= {h_blank, h_sync, disp_en};
            if (h_blank && !last_ff[2]) blank_on <= pos_ff;
            if (!h_blank && last_ff[2]) blank_off <= pos_ff;
            if (h_sync && !last_ff[1]) sync_on <= pos_ff;
            if (disp_en && !last_ff[0]) disp_on <= pos_ff;
            if (!h_sync && last_ff[1]) sync_off <= pos_ff;
            if (!disp_en && last_ff[0]) disp_off <= pos_ff;
        end
    end
endmodule : display_sink

// file: test/hblank_sync_assertions.sv
/* Port checker for the horizontal timing block.
   Assumes char_en is held high, so one character passes per clock. */
`timescale 1ns/1ps
module hblank_sync_assertions
    import hblank_sync_pkg::*;
(
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic char_en,
    input wire logic text_mode,
    input wire logic index_wr,
    input wire logic data_wr,
    input wire logic data_rd,
    input wire logic [7:0] wr_data,
    input wire logic [7:0] index_q,
    input wire logic [7:0] rd_data,
    input wire logic h_blank,
    input wire logic h_sync,
    input wire logic disp_en,
    input wire logic line_start
);
    logic [7:0] bs_ff, ss_ff, pos_ff;
    logic prot_ff;
    logic wr_ok;
    // Protected writes must leave the shadows alone, as in the block
    assign wr_ok = data_wr && !(prot_ff && index_q[6:0] <= group0_last_idx);
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            {bs_ff, ss_ff, pos_ff, prot_ff} <= {blank_start_rst,
                sync_start_rst, 8'h00, 1'b0};
        end else begin
            pos_ff <= line_start ? 8'h01 : pos_ff + 8'h01;
            if (wr_ok && index_q[6:0] == blank_start_idx) bs_ff <= wr_data;
            if (wr_ok && index_q[6:0] == sync_start_idx) ss_ff <= wr_data;
            if (data_wr && index_q[6:0] == protect_idx) prot_ff <= wr_data[7];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!reset_n);
    sequence s_rd_bs; data_rd && index_q[6:0] == blank_start_idx; endsequence
    sequence s_rd_ss; data_rd && index_q[6:0] == sync_start_idx; endsequence
    property p_index_load;
        index_wr |=> index_q == ($past(wr_data) & 8'h7F);
    endproperty
    property p_index_hold; !index_wr |=> $stable(index_q); endproperty
    property p_rd_hold; !data_rd |=> $stable(rd_data); endproperty
    property p_be_top;
        data_rd && index_q[6:0] == blank_end_skew_idx |=> rd_data[7];
    endproperty
    property p_bs_read; s_rd_bs |=> rd_data == $past(bs_ff); endproperty
    property p_ss_read; s_rd_ss |=> rd_data == $past(ss_ff); endproperty
    // Compare against the start value that stood when the count matched
    property p_blank_rise;
        $rose(h_blank) |-> pos_ff == $past(bs_ff) + 8'h01;
    endproperty
    property p_line_gap; line_start |=> !line_start [*4]; endproperty
    a_index_load: assert property (p_index_load)
        else $error("index not loaded");
    a_index_hold: assert property (p_index_hold)
        else $error("index moved");
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved");
    a_be_top: assert property (p_be_top)
        else $error("blank end top bit not one");
    a_bs_read: assert property (p_bs_read)
        else $error("blank start readback wrong");
    a_ss_read: assert property (p_ss_read)
        else $error("sync start readback wrong");
    a_blank_rise: assert property (p_blank_rise)
        else $error("blanking began at wrong count");
    a_line_gap: assert property (p_line_gap)
        else $error("line shorter than five characters");
endmodule : hblank_sync_assertions
bind hblank_sync hblank_sync_assertions chk (.sys_clk, .reset_n, .char_en,
    .text_mode, .index_wr, .data_wr, .data_rd, .wr_data, .index_q, .rd_data,
    .h_blank, .h_sync, .disp_en, .line_start);

// file: test/testbench.sv
/* Register and line timing test of the horizontal timing block.
   Assumes char_en held high: one character per clock, until the last check drives it low. */
`timescale 1ns/1ps
module testbench;
    import hblank_sync_pkg::*;
    logic sys_clk, reset_n, char_en, text_mode, index_wr, data_wr, data_rd;
    logic [7:0] wr_data, index_q, rd_data, b_on, b_off, s_on, d_on, s_off;
    logic [7:0] d_off, v;
    logic h_blank, h_sync, disp_en, line_start;
    int err_count = 0;
    int n_compared = 0;
    hblank_sync uut (.sys_clk, .reset_n, .char_en, .text_mode, .index_wr,
        .data_wr, .data_rd, .wr_data, .index_q, .rd_data, .h_blank,
        .h_sync, .disp_en, .line_start);
    display_sink sink (.sys_clk, .reset_n, .h_blank, .h_sync, .disp_en,
        .line_start, .blank_on(b_on), .blank_off(b_off), .sync_on(s_on),
        .disp_on(d_on), .sync_off(s_off), .disp_off(d_off));
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    task conclude;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    task check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One strobe state per cycle, so every pulse lasts exactly one cycle
    task step(input logic iw, dw, dr, input logic [7:0] d);
        @(negedge sys_clk);
        {index_wr, data_wr, data_rd, wr_data} = {iw, dw, dr, d};
    endtask : step
    task wr(input logic [7:0] idx, val);
        step(1'b1, 1'b0, 1'b0, idx);
        step(1'b0, 1'b1, 1'b0, val);
        step(1'b0, 1'b0, 1'b0, val);
    endtask : wr
    task rdchk(input logic [7:0] idx, exp);
        step(1'b1, 1'b0, 1'b0, idx);
        step(1'b0, 1'b0, 1'b1, idx);
        step(1'b0, 1'b0, 1'b0, idx);
        check(rd_data, exp);
    endtask : rdchk
    // Bounded wait for line pulses; a stuck counter ends the run
    task lines(input int n);
        int i;
        repeat (n) begin
            for (i = 0; i < 300; i++) begin
                @(negedge sys_clk);
                if (line_start) break;
            end
            if (i == 300) begin
                err_count++;
                conclude;
            end
        end
    endtask : lines
    initial begin
        {reset_n, text_mode, index_wr, data_wr, data_rd} = 5'h00;
        char_en = 1'b1;
        wr_data = 8'h00;
        repeat (16) @(posedge sys_clk);
        @(negedge sys_clk) reset_n = 1'b1;
        rdchk(8'h02, blank_start_rst);
        rdchk(8'h03, blank_end_skew_rst);
        rdchk(8'h04, sync_start_rst);
        rdchk(8'h20, 8'h00);
        wr(8'h03, 8'h00);
        rdchk(8'h03, 8'h80);
        // 64-character line, blank 40..48 so bit 5 of blank end matters
        wr(8'h00, 8'h3B);
        wr(8'h01, 8'h1F);
        wr(8'h02, 8'h28);
        wr(8'h04, 8'h2B);
        for (int d = 0; d < 5; d++) begin
            text_mode = (d == 4);
            wr(8'h05, {1'b1, d[1:0], 5'h0E});
            wr(8'h03, {1'b0, d[1:0], 5'h10});
            lines(3);
            check(b_on, 8'h29);
            check(b_off, 8'h31);
            check(s_on, 8'h2D + 8'(d % 4) + 8'(d / 4));
            check(s_off, 8'h30 + 8'(d % 4) + 8'(d / 4));
            check(d_on, 8'h01 + 8'(d % 4));
            check(d_off, 8'h21 + 8'(d % 4));
        end
        text_mode = 1'b0;
        wr(8'h11, 8'h80);
        wr(8'h04, 8'h20);
        rdchk(8'h04, 8'h2B);
        wr(8'h02, 8'h10);
        rdchk(8'h02, 8'h28);
        wr(8'h11, 8'h00);
        wr(8'h04, 8'h2C);
        rdchk(8'h04, 8'h2C);
        check(index_q, 8'h04);
        // A character enable held low freezes the line, so no line start comes
        char_en = 1'b0;
        v = 8'h00;
        repeat (100) begin
            @(negedge sys_clk);
            if (line_start) v = v + 8'h01;
        end
        check(v, 8'h00);
        conclude;
    end
endmodule : testbench
